// ==== design/smrs_pkg.sv ====
`default_nettype none
package smrs_pkg;
	// Recovery counter geometry
	localparam int          SMRS_CNT_W      = 12;
	localparam logic [11:0] SMRS_CNT_RST    = 12'h000;
	localparam logic [11:0] SMRS_CNT_STEP   = 12'h001;
	// Last count before the terminal value (4096 and 32 reference edges)
	localparam logic [11:0] SMRS_LONG_LAST  = 12'hFFF;
	localparam logic [11:0] SMRS_SHORT_LAST = 12'h01F;
	// Edge totals, used by checks only
	localparam logic [12:0] SMRS_LONG_EDGES  = 13'h1000;
	localparam logic [12:0] SMRS_SHORT_EDGES = 13'h0020;
	localparam logic [12:0] SMRS_EDGE_STEP   = 13'h0001;

	typedef enum logic [1:0] {SMRS_RUN, SMRS_STOP, SMRS_RECOVER} smrs_state_t;

	// Terminal count selected by the long/short choice
	function automatic logic [11:0] smrs_last(input logic long_sel);
		smrs_last = long_sel ? SMRS_LONG_LAST : SMRS_SHORT_LAST;
	endfunction
endpackage
`default_nettype wire

// ==== design/smrs_cnt_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface smrs_cnt_if;
	logic        clear;
	logic        advance;
	logic        long_sel;
	logic        done;
	logic [11:0] count;
	modport ctrl (output clear, output advance, output long_sel, input done, input count);
	modport cnt  (input clear, input advance, input long_sel, output done, output count);
endinterface
`default_nettype wire

// ==== design/smrs_rec_counter.sv ====
`timescale 1ns/1ns
`default_nettype none
module smrs_rec_counter
	import smrs_pkg::*;
(
	// Clock and control
	input  wire logic mclk_i,
	input  wire logic sys_rst_i,
	input  wire logic ce_i,
	// Sequencer side
	smrs_cnt_if.cnt   cnt_port
);
	typedef struct packed {
		logic [11:0] count;
	} smrs_cnt_st_t;

	smrs_cnt_st_t cnt_reg;
	smrs_cnt_st_t cnt_next;

	// Clear wins over advance; wraps freely outside stop
	always_comb
	begin
		cnt_next = cnt_reg;
		if (cnt_port.clear)
			cnt_next.count = SMRS_CNT_RST;
		else if (cnt_port.advance)
			cnt_next.count = cnt_reg.count + SMRS_CNT_STEP;
	end

	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			cnt_reg <= '{count: SMRS_CNT_RST};
		else if (ce_i)
			cnt_reg <= cnt_next;
	end

	assign cnt_port.count = cnt_reg.count;
	assign cnt_port.done  = cnt_port.advance && !cnt_port.clear
	                        && (cnt_reg.count == smrs_last(cnt_port.long_sel));

	adv_step_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		ce_i && cnt_port.advance && !cnt_port.clear |=> cnt_reg.count == $past(cnt_reg.count) + SMRS_CNT_STEP)
		else $error("counter did not step on reference edge");
	done_cmp_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cnt_port.done |-> cnt_reg.count == smrs_last(cnt_port.long_sel))
		else $error("done raised off terminal count");
endmodule
`default_nettype wire

// ==== design/smrs_sequencer.sv ====
`timescale 1ns/1ns
`default_nettype none
module smrs_sequencer
	import smrs_pkg::*;
(
	// Clock, reset, enable
	input  wire logic  mclk_i,
	input  wire logic  sys_rst_i,
	input  wire logic  ce_i,
	// CPU and wakeup sources
	input  wire logic  stop_instr_i,
	input  wire logic  wake_irq_i,
	input  wire logic  reset_wake_i,
	// Configuration
	input  wire logic  short_recovery_select_i,
	input  wire logic  osc_run_in_stop_i,
	// Reference clock falling edge strobe
	input  wire logic  ref_fall_i,
	// Clock gating
	output logic       cpu_clk_en_o,
	output logic       periph_clk_en_o,
	output logic       clock_gen_bus_out_en_o,
	output logic       clock_gen_ref_clock_en_o,
	// Status and events
	output logic       stop_active_o,
	output logic       recovering_o,
	output logic       irq_mask_clear_o,
	output logic       stacking_start_o,
	output logic [11:0] recovery_count_o
);
	typedef struct packed {
		smrs_state_t st;
		logic        long_sel;
		logic        irq_exit;
		logic        osc_keep;
		logic        cpu_en;
		logic        per_en;
		logic        bus_en;
		logic        ref_en;
		logic        mask_clr;
		logic        stack;
	} smrs_seq_st_t;

	smrs_seq_st_t seq_reg;
	smrs_seq_st_t seq_next;
	smrs_cnt_if   cnt_bus ();

	smrs_rec_counter u_counter (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.cnt_port  (cnt_bus.cnt)
	);

	// Counter steering from the sequencer state
	always_comb
	begin
		cnt_bus.clear    = (seq_reg.st == SMRS_STOP);
		cnt_bus.advance  = (seq_reg.st != SMRS_STOP) && ref_fall_i;
		cnt_bus.long_sel = seq_reg.long_sel;
	end

	// Next state; pulses drop by default
	always_comb
	begin
		seq_next          = seq_reg;
		seq_next.mask_clr = 1'b0;
		seq_next.stack    = 1'b0;
		case (seq_reg.st)
			SMRS_RUN:
			begin
				if (stop_instr_i)
				begin
					seq_next.st       = SMRS_STOP;
					seq_next.mask_clr = 1'b1;
					seq_next.cpu_en   = 1'b0;
					seq_next.per_en   = 1'b0;
					seq_next.osc_keep = osc_run_in_stop_i;
					seq_next.bus_en   = osc_run_in_stop_i;
					seq_next.ref_en   = osc_run_in_stop_i;
				end
			end
			SMRS_STOP:
			begin
				if (reset_wake_i)
				begin
					seq_next.st       = SMRS_RECOVER;
					seq_next.long_sel = 1'b1;
					seq_next.irq_exit = 1'b0;
					seq_next.bus_en   = 1'b1;
					seq_next.ref_en   = 1'b1;
				end
				else if (wake_irq_i)
				begin
					seq_next.st       = SMRS_RECOVER;
					seq_next.long_sel = !short_recovery_select_i;
					seq_next.irq_exit = 1'b1;
					seq_next.bus_en   = 1'b1;
					seq_next.ref_en   = 1'b1;
				end
			end
			SMRS_RECOVER:
			begin
				// A reset mid-recovery stretches to the long delay
				if (reset_wake_i)
				begin
					seq_next.long_sel = 1'b1;
					seq_next.irq_exit = 1'b0;
				end
				if (cnt_bus.done)
				begin
					seq_next.st     = SMRS_RUN;
					seq_next.cpu_en = 1'b1;
					seq_next.per_en = 1'b1;
					seq_next.stack  = seq_reg.irq_exit && !reset_wake_i;
				end
			end
			default:
			begin
				seq_next.st = SMRS_RUN;
			end
		endcase
	end

	// State register; low enable freezes everything, pulses included
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			seq_reg <= '{st: SMRS_RUN, long_sel: 1'b1, irq_exit: 1'b0, osc_keep: 1'b0,
			             cpu_en: 1'b1, per_en: 1'b1, bus_en: 1'b1, ref_en: 1'b1,
			             mask_clr: 1'b0, stack: 1'b0};
		else if (ce_i)
			seq_reg <= seq_next;
	end

	freeze_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!ce_i |=> $stable(seq_reg))
		else $error("state moved while enable low");

	// Outputs straight from flops, except stop_active_o and recovering_o, which decode the state register
	assign cpu_clk_en_o             = seq_reg.cpu_en;
	assign periph_clk_en_o          = seq_reg.per_en;
	assign clock_gen_bus_out_en_o   = seq_reg.bus_en;
	assign clock_gen_ref_clock_en_o = seq_reg.ref_en;
	assign stop_active_o            = (seq_reg.st == SMRS_STOP);
	assign recovering_o             = (seq_reg.st == SMRS_RECOVER);
	assign irq_mask_clear_o         = seq_reg.mask_clr;
	assign stacking_start_o         = seq_reg.stack;
	assign recovery_count_o         = cnt_bus.count;

	// Check helper: reference edges seen during one recovery
	logic [12:0] edges_reg;
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || seq_reg.st != SMRS_RECOVER)
			edges_reg <= 13'h0000;
		else if (ce_i && ref_fall_i)
			edges_reg <= edges_reg + SMRS_EDGE_STEP;
	end

	stop_gating_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		seq_reg.st == SMRS_STOP |-> !cpu_clk_en_o && !periph_clk_en_o && cnt_bus.clear)
		else $error("core clocks running in stop");
	osc_off_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		seq_reg.st == SMRS_STOP && !seq_reg.osc_keep
		|-> !clock_gen_bus_out_en_o && !clock_gen_ref_clock_en_o)
		else $error("oscillator outputs on in stop");
	no_early_clk_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		seq_reg.st == SMRS_RECOVER && !cnt_bus.done |=> !cpu_clk_en_o && !periph_clk_en_o)
		else $error("clocks restarted before timeout");
	exit_cause_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		seq_reg.st == SMRS_STOP && ce_i && !wake_irq_i && !reset_wake_i
		|=> seq_reg.st == SMRS_STOP)
		else $error("stop left without wakeup");
	delay_len_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		ce_i && cnt_bus.done && seq_reg.st == SMRS_RECOVER
		|-> edges_reg + SMRS_EDGE_STEP == (seq_reg.long_sel ? SMRS_LONG_EDGES : SMRS_SHORT_EDGES))
		else $error("recovery length wrong");
	stack_after_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		stacking_start_o |-> $past(seq_reg.st) == SMRS_RECOVER && seq_reg.st == SMRS_RUN)
		else $error("stacking before recovery end");
	reset_long_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		seq_reg.st == SMRS_STOP && ce_i && reset_wake_i |=> seq_reg.long_sel && !seq_reg.irq_exit)
		else $error("reset exit not long");
	clear_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		seq_reg.st == SMRS_STOP && ce_i |=> cnt_bus.count == SMRS_CNT_RST)
		else $error("counter not held in stop");
	mask_clear_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		seq_reg.st == SMRS_RUN && ce_i && stop_instr_i |=> irq_mask_clear_o && stop_active_o)
		else $error("mask not cleared on stop");

	short_exit_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
		stacking_start_o && !$past(seq_reg.long_sel));
	long_exit_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
		stacking_start_o && $past(seq_reg.long_sel));
	reset_exit_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
		seq_reg.st == SMRS_STOP && reset_wake_i);
	osc_kept_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
		seq_reg.st == SMRS_STOP && clock_gen_ref_clock_en_o);
endmodule
`default_nettype wire

// ==== test/smrs_far_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module smrs_far_model
(
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic sys_rst_i,
	// Wakeup request from the bench
	input  wire logic wake_req_i,
	// Reference clock enable from the sequencer
	input  wire logic ref_en_i,
	// Toward the sequencer
	output logic      ref_fall_o,
	output logic      wake_irq_o
);
	logic div_reg = 1'b0;
	// Reference edge every second cycle, so long waits stay short;
	// no edges while the reference clock is switched off in stop
	always @(posedge mclk_i)
	begin
		if (sys_rst_i || !ref_en_i)
		begin
			div_reg <= 1'b0;
			ref_fall_o <= 1'b0;
		end
		else
		begin
			div_reg <= ~div_reg;
			ref_fall_o <= div_reg;
		end
	end
	// A stop-active module holds its interrupt as a level
	assign wake_irq_o = wake_req_i;
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
	import smrs_pkg::*;
	// Bench drive and observed outputs
	logic        mclk_i, sys_rst_i, stop_i, rwake, short_sel, osc_run, wake_req, ce;
	logic        wake_irq, ref_fall, cpu_en, per_en, bus_en, ref_en;
	logic        s_act, rec, mclr, stk;
	logic [11:0] cnt;
	int          err_total;
	int          total_checks;

	smrs_far_model u_far (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wake_req_i(wake_req),
		.ref_en_i(ref_en), .ref_fall_o(ref_fall), .wake_irq_o(wake_irq));
	smrs_sequencer u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
		.stop_instr_i(stop_i), .wake_irq_i(wake_irq), .reset_wake_i(rwake),
		.short_recovery_select_i(short_sel), .osc_run_in_stop_i(osc_run),
		.ref_fall_i(ref_fall), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
		.clock_gen_bus_out_en_o(bus_en), .clock_gen_ref_clock_en_o(ref_en),
		.stop_active_o(s_act), .recovering_o(rec), .irq_mask_clear_o(mclr),
		.stacking_start_o(stk), .recovery_count_o(cnt));

	// 100 ns clock
	initial
	begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Stop entry, then a quiet stretch; reference edges run only when osc is set
	task automatic enter_stop(input logic osc);
		osc_run = osc;
		stop_i = 1'b1;
		@(negedge mclk_i);
		stop_i = 1'b0;
		chk(13'({s_act, cpu_en, per_en}), 13'h4);
		chk(13'({bus_en, ref_en}), {11'h0, osc, osc});
		chk(13'(mclr), 13'h1);
		@(negedge mclk_i);
		chk(13'(mclr), 13'h0);
		repeat (6) @(negedge mclk_i);
		chk(13'({s_act, rec}), 13'h2);
		chk(13'(cnt), 13'h0);
	endtask

	// Wake, count reference edges seen in recovery, judge the exit
	task automatic recover(input logic by_rst, input logic sh, input logic [12:0] exp_n);
		logic [12:0] n;
		logic        seen;
		logic        early;
		n = 13'h0000;
		seen = 1'b0;
		early = 1'b0;
		short_sel = sh;
		if (by_rst)
			rwake = 1'b1;
		else
			wake_req = 1'b1;
		repeat (20000)
		begin
			@(negedge mclk_i);
			if (rec === 1'b1)
			begin
				seen = 1'b1;
				early = early | cpu_en | per_en | stk;
				if (ref_fall === 1'b1)
					n++;
			end
			else if (seen)
				break;
		end
		chk(n, exp_n);
		chk(13'({early, cpu_en, per_en}), 13'h3);
		chk(13'(stk), {12'h000, !by_rst});
		@(negedge mclk_i);
		rwake = 1'b0;
		wake_req = 1'b0;
		chk(13'({stk, bus_en, ref_en}), 13'h3);
	endtask

	// Low enable: a stop request is not taken and the counter holds
	task automatic freeze_check();
		logic [11:0] held;
		ce = 1'b0;
		stop_i = 1'b1;
		@(negedge mclk_i);
		held = cnt;
		repeat (4) @(negedge mclk_i);
		chk(13'({s_act, mclr, cpu_en}), 13'h1);
		chk(13'(cnt), 13'(held));
		stop_i = 1'b0;
		ce = 1'b1;
		@(negedge mclk_i);
		chk(13'(s_act), 13'h0);
	endtask

	// System reset while stopped returns everything to run
	task automatic reset_in_stop();
		enter_stop(1'b0);
		sys_rst_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		chk(13'({s_act, rec, cpu_en, per_en, bus_en, ref_en}), 13'hF);
		chk(13'({cnt, mclr}), 13'h0000);
		@(negedge mclk_i);
		chk(13'({s_act, rec, cpu_en, stk}), 13'h2);
	endtask

	// Main sequence
	initial
	begin
		err_total = 0;
		total_checks = 0;
		sys_rst_i = 1'b1;
		{stop_i, rwake, short_sel, osc_run, wake_req} = 5'h00;
		ce = 1'b1;
		repeat (4) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		wake_req = 1'b1;
		repeat (3) @(negedge mclk_i);
		chk(13'({rec, s_act, cpu_en}), 13'h1);
		wake_req = 1'b0;
		freeze_check();
		enter_stop(1'b0);
		recover(1'b0, 1'b1, SMRS_SHORT_EDGES);
		enter_stop(1'b1);
		// crystal setup keeps the long delay
		recover(1'b0, 1'b0, SMRS_LONG_EDGES);
		enter_stop(1'b0);
		recover(1'b1, 1'b1, SMRS_LONG_EDGES);
		reset_in_stop();
		final_report();
	end

	// Watchdog well beyond two long recoveries
	initial
	begin
		repeat (40000) @(posedge mclk_i);
		err_total++;
		final_report();
	end
endmodule
`default_nettype wire
